// file: hdl/quad_counter_pwm_capture.sv
// What this block does
// - Four 8-bit counters, pairs chain to 16
// - Two PWM pins, width 8 to 16
// - Capture on first pair, selectable source
// - One capture signal serves both counters
// - First pair mixes count, capture, PWM
// - Second pair: count, or PWM plus count
// - Counter write sets comparison value
// - First pair reads live or captured value
// - Second pair always reads live value
// - Two-bit clock select per counter
// - Direction bit per counter, 0 down
// - Config bits 2 and 3 chain pairs
// - Config bits 0 and 1 enable PWM
// - Capture source and edge, reset zero
// - One interrupt/event line per counter
// - Capture on rising, falling or both
// - Port A pins clock the counters
// - Counter-mode write reloads live count
// - PWM-mode write leaves count alone
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
module quad_counter_pwm_capture
  import qcp_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [3:0] ext_clock_pins_in,
  input wire logic [2:0] int_clocks_in,
  input wire logic [3:0] capture_sources_in,
  output logic [7:0] rdata_out,
  output logic pwm_pin0_out,
  output logic pwm_pin1_out,
  output logic first_irq_out,
  output logic second_irq_out,
  output logic third_irq_out,
  output logic fourth_irq_out
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Mask of active bits for a chained PWM width code
  function automatic logic [15:0] width_mask(input logic [1:0] code);
    logic [15:0] m;
    m = 16'h03ff;
    unique case (code)
      2'h0: m = 16'h03ff;
      2'h1: m = 16'h0fff;
      2'h2: m = 16'h3fff;
      2'h3: m = 16'hffff;
    endcase
    return m;
  endfunction

  // One counter step in the chosen direction
  function automatic logic [7:0] step8(input logic [7:0] v, input logic up);
    return up ? 8'(v + 8'h01) : 8'(v - 8'h01);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] cmp_reg [4];
  logic [7:0] cnt_reg [4];
  logic [7:0] cnt_next [4];
  logic [7:0] cap_reg [2];
  logic [7:0] clk_sel_reg;
  logic [7:0] cfg1_reg;
  logic [7:0] cfg2_reg;
  logic [3:0] run_reg;
  logic [7:0] rdata_reg;
  logic [3:0] irq_reg;
  logic [3:0] irq_next;
  logic pwm0_reg;
  logic pwm1_reg;
  logic cap_prev_reg;
  logic [3:0] reload_reg;

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  logic chain_low_pair;
  logic chain_high_pair;
  logic pwm_out0_enable;
  logic pwm_out1_enable;
  logic [3:0] direction;
  logic [1:0] capture_source_select;
  logic [1:0] capture_edge_function;
  logic [1:0] pwm_out0_width;
  logic [1:0] pwm_out1_width;
  logic capture_on;
  assign chain_low_pair = cfg1_reg[CFG1_CHAIN_LO];
  assign chain_high_pair = cfg1_reg[CFG1_CHAIN_HI];
  assign pwm_out0_enable = cfg1_reg[CFG1_PWM0];
  assign pwm_out1_enable = cfg1_reg[CFG1_PWM1];
  assign direction = cfg1_reg[CFG1_DIR0 +: 4];
  assign capture_source_select = cfg2_reg[CFG2_CAPS +: 2];
  assign capture_edge_function = cfg2_reg[CFG2_CAPF +: 2];
  assign pwm_out0_width = cfg2_reg[CFG2_PW0 +: 2];
  assign pwm_out1_width = cfg2_reg[CFG2_PW1 +: 2];
  // capture is live whenever an edge function is chosen
  assign capture_on = capture_edge_function != CAP_OFF;

  // ----------------------------------------
  // Clock ticks
  // ----------------------------------------
  logic [3:0] tick;
  logic [3:0] src [4];
  // pin per counter, plus shared internal clocks
  assign src[0] = {int_clocks_in[2], int_clocks_in[1], int_clocks_in[0], ext_clock_pins_in[0]};
  assign src[1] = {int_clocks_in[2], int_clocks_in[1], int_clocks_in[0], ext_clock_pins_in[1]};
  assign src[2] = {int_clocks_in[2], int_clocks_in[1], int_clocks_in[0], ext_clock_pins_in[2]};
  assign src[3] = {int_clocks_in[2], int_clocks_in[1], int_clocks_in[0], ext_clock_pins_in[3]};

  // each counter picks its source from its two select bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tick
      qcp_tick u_tick (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .src_in(src[gi]),
        .sel_in(clk_sel_reg[2*gi +: 2]),
        .tick_out(tick[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Run enables and chained advance
  // ----------------------------------------
  logic [3:0] run_eff;
  logic [3:0] adv;
  logic [3:0] chained;
  logic [3:0] in_pwm;
  // low enable and low clock drive the high counter when chained
  assign run_eff[0] = run_reg[0];
  assign run_eff[1] = chain_low_pair ? run_reg[0] : run_reg[1];
  assign run_eff[2] = run_reg[2];
  assign run_eff[3] = chain_high_pair ? run_reg[2] : run_reg[3];
  assign chained = {chain_high_pair, chain_high_pair, chain_low_pair, chain_low_pair};
  // PWM takes the low counter, or both when chained
  assign in_pwm = {pwm_out1_enable & chain_high_pair, pwm_out1_enable,
                   pwm_out0_enable & chain_low_pair, pwm_out0_enable};
  assign adv[0] = run_eff[0] & tick[0];
  assign adv[2] = run_eff[2] & tick[2];

  // 16-bit views of the pairs
  logic [15:0] pair_cnt [2];
  logic [15:0] pair_cmp [2];
  logic [15:0] pair_mask [2];
  logic [1:0] pair_up;
  logic [1:0] pair_carry;
  assign pair_cnt[0] = {cnt_reg[1], cnt_reg[0]};
  assign pair_cnt[1] = {cnt_reg[3], cnt_reg[2]};
  assign pair_cmp[0] = {cmp_reg[1], cmp_reg[0]};
  assign pair_cmp[1] = {cmp_reg[3], cmp_reg[2]};
  // chained PWM width from the size field
  assign pair_mask[0] = width_mask(pwm_out0_width);
  assign pair_mask[1] = width_mask(pwm_out1_width);
  // PWM always counts down; otherwise low counter's direction rules the pair
  assign pair_up[0] = direction[0] & ~pwm_out0_enable;
  assign pair_up[1] = direction[2] & ~pwm_out1_enable;
  // carry from low to high counter
  assign pair_carry[0] = pair_up[0] ? (cnt_reg[0] == 8'hff) : (cnt_reg[0] == 8'h00);
  assign pair_carry[1] = pair_up[1] ? (cnt_reg[2] == 8'hff) : (cnt_reg[2] == 8'h00);
  assign adv[1] = chain_low_pair ? (adv[0] & pair_carry[0]) : (run_eff[1] & tick[1]);
  assign adv[3] = chain_high_pair ? (adv[2] & pair_carry[1]) : (run_eff[3] & tick[3]);

  // ----------------------------------------
  // Effective direction
  // ----------------------------------------
  logic [3:0] up_eff;
  assign up_eff = {chain_high_pair ? pair_up[1] : (direction[3] & ~in_pwm[3]),
                   pair_up[1],
                   chain_low_pair ? pair_up[0] : (direction[1] & ~in_pwm[1]),
                   pair_up[0]};
  // ----------------------------------------
  // Capture edge
  // ----------------------------------------
  logic cap_lvl;
  logic cap_evt;
  // one capture signal for both first-pair counters
  assign cap_lvl = capture_sources_in[capture_source_select];
  assign cap_evt = ((capture_edge_function == CAP_RISE) & cap_lvl & ~cap_prev_reg) |
                   ((capture_edge_function == CAP_FALL) & ~cap_lvl & cap_prev_reg) |
                   ((capture_edge_function == CAP_BOTH) & (cap_lvl ^ cap_prev_reg));

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [3:0] cnt_wr;
  assign cnt_wr[0] = wr_in & (addr_in == ADDR_CNT_A);
  assign cnt_wr[1] = wr_in & (addr_in == ADDR_CNT_B);
  assign cnt_wr[2] = wr_in & (addr_in == ADDR_CNT_C);
  assign cnt_wr[3] = wr_in & (addr_in == ADDR_CNT_D);

  // read mux: only the first pair can show captured values
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = RESERVED_READ;
    unique case (addr_in)
      ADDR_CNT_A: rd_mux = capture_on ? cap_reg[0] : cnt_reg[0];
      ADDR_CNT_B: rd_mux = capture_on ? cap_reg[1] : cnt_reg[1];
      ADDR_CNT_C: rd_mux = cnt_reg[2];
      ADDR_CNT_D: rd_mux = cnt_reg[3];
      ADDR_CLK_SEL: rd_mux = clk_sel_reg;
      ADDR_CFG1: rd_mux = cfg1_reg;
      ADDR_CFG2: rd_mux = cfg2_reg;
      ADDR_RUN: rd_mux = {4'h0, run_reg};
    endcase
  end

  // ----------------------------------------
  // Counter next state
  // ----------------------------------------
  // A write in counter mode is held as a pending reload until the counter
  // next steps, since the live count only moves on its own clock ticks.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cnt_next[i] = cnt_reg[i];
      irq_next[i] = 1'b0;
      if (adv[i]) begin
        if (reload_reg[i]) begin
          cnt_next[i] = up_eff[i] ? 8'h00 : cmp_reg[i];
        end else if (in_pwm[i] && !chained[i] && (cnt_reg[i] == 8'h00)) begin
          // 8-bit PWM period wraps at zero to full scale
          cnt_next[i] = 8'hff;
        end else begin
          cnt_next[i] = step8(cnt_reg[i], up_eff[i]);
        end
      end
    end
    // Chained PWM wraps the pair at the selected width
    if (in_pwm[1] && adv[0] && !reload_reg[0] && ((pair_cnt[0] & pair_mask[0]) == 16'h0000)) begin
      cnt_next[0] = pair_mask[0][7:0];
      cnt_next[1] = pair_mask[0][15:8];
    end
    if (in_pwm[3] && adv[2] && !reload_reg[2] && ((pair_cnt[1] & pair_mask[1]) == 16'h0000)) begin
      cnt_next[2] = pair_mask[1][7:0];
      cnt_next[3] = pair_mask[1][15:8];
    end
    // one-cycle pulse on reaching compare in counter mode
    irq_next[0] = adv[0] & ~in_pwm[0] &
                  (chain_low_pair ? ({cnt_next[1], cnt_next[0]} == pair_cmp[0])
                                  : (cnt_next[0] == cmp_reg[0]));
    irq_next[1] = adv[1] & ~in_pwm[1] & ~chain_low_pair & (cnt_next[1] == cmp_reg[1]);
    irq_next[2] = adv[2] & ~in_pwm[2] &
                  (chain_high_pair ? ({cnt_next[3], cnt_next[2]} == pair_cmp[1])
                                   : (cnt_next[2] == cmp_reg[2]));
    irq_next[3] = adv[3] & ~in_pwm[3] & ~chain_high_pair & (cnt_next[3] == cmp_reg[3]);
    // capture replaces first-pair compare irqs; counter A stays quiet in PWM, B pulses even in chained PWM
    if (capture_on) begin
      irq_next[0] = cap_evt & ~in_pwm[0];
      irq_next[1] = cap_evt;
    end
  end

  // ----------------------------------------
  // Register file and counters
  // ----------------------------------------
  // Config bits without a documented reset start at zero for determinism
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sel_reg <= CFG_RESET;
      cfg1_reg <= CFG_RESET;
      cfg2_reg <= CFG_RESET;
      run_reg <= RUN_RESET;
    end else if (wr_in) begin
      // clock select taken as written; software stops first
      if (addr_in == ADDR_CLK_SEL) clk_sel_reg <= wdata_in;
      if (addr_in == ADDR_CFG1) cfg1_reg <= wdata_in;
      if (addr_in == ADDR_CFG2) cfg2_reg <= wdata_in;
      if (addr_in == ADDR_RUN) run_reg <= wdata_in[3:0];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        cmp_reg[i] <= 8'h00;
        cnt_reg[i] <= 8'h00;
      end
      reload_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt_reg[i] <= cnt_next[i];
        if (cnt_wr[i]) cmp_reg[i] <= wdata_in;
        // reload pending only outside PWM; new write wins over clear
        if (cnt_wr[i] && !in_pwm[i]) reload_reg[i] <= 1'b1;
        else if (adv[i]) reload_reg[i] <= 1'b0;
      end
    end
  end

  // Capture latches and edge history
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_reg[0] <= 8'h00;
      cap_reg[1] <= 8'h00;
      cap_prev_reg <= 1'b0;
    end else begin
      cap_prev_reg <= cap_lvl;
      // both counters caught by the same event
      if (cap_evt) begin
        cap_reg[0] <= cnt_reg[0];
        cap_reg[1] <= cnt_reg[1];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // PWM high while count below compare, over the chosen width
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm0_reg <= 1'b0;
      pwm1_reg <= 1'b0;
      irq_reg <= 4'h0;
      rdata_reg <= 8'h00;
    end else begin
      pwm0_reg <= pwm_out0_enable & (chain_low_pair
                  ? ((pair_cnt[0] & pair_mask[0]) < (pair_cmp[0] & pair_mask[0]))
                  : (cnt_reg[0] < cmp_reg[0]));
      pwm1_reg <= pwm_out1_enable & (chain_high_pair
                  ? ((pair_cnt[1] & pair_mask[1]) < (pair_cmp[1] & pair_mask[1]))
                  : (cnt_reg[2] < cmp_reg[2]));
      irq_reg <= irq_next;
      rdata_reg <= rd_in ? rd_mux : 8'h00;
    end
  end

  assign rdata_out = rdata_reg;
  assign pwm_pin0_out = pwm0_reg;
  assign pwm_pin1_out = pwm1_reg;
  assign first_irq_out = irq_reg[0];
  assign second_irq_out = irq_reg[1];
  assign third_irq_out = irq_reg[2];
  assign fourth_irq_out = irq_reg[3];
endmodule

// file: hdl/qcp_pkg.sv
package qcp_pkg;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [2:0] ADDR_CNT_A = 3'h0;
  localparam logic [2:0] ADDR_CNT_B = 3'h1;
  localparam logic [2:0] ADDR_CNT_C = 3'h2;
  localparam logic [2:0] ADDR_CNT_D = 3'h3;
  localparam logic [2:0] ADDR_CLK_SEL = 3'h4;
  localparam logic [2:0] ADDR_CFG1 = 3'h5;
  localparam logic [2:0] ADDR_CFG2 = 3'h6;
  localparam logic [2:0] ADDR_RUN = 3'h7;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CFG1_PWM0 = 0;
  localparam int CFG1_PWM1 = 1;
  localparam int CFG1_CHAIN_LO = 2;
  localparam int CFG1_CHAIN_HI = 3;
  localparam int CFG1_DIR0 = 4;
  localparam int CFG2_PW0 = 0;
  localparam int CFG2_PW1 = 2;
  localparam int CFG2_CAPF = 4;
  localparam int CFG2_CAPS = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] RUN_RESET = 4'h0;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  // Clock select codes
  localparam logic [1:0] CK_PIN = 2'h0;
  localparam logic [1:0] CK_SRC1 = 2'h1;
  localparam logic [1:0] CK_SRC2 = 2'h2;
  localparam logic [1:0] CK_SRC3 = 2'h3;
  // Capture edge codes
  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_RISE = 2'h1;
  localparam logic [1:0] CAP_FALL = 2'h2;
  localparam logic [1:0] CAP_BOTH = 2'h3;
endpackage

// file: hdl/qcp_tick.sv
// ----------------------------------------
// Rising-edge detector on a sampled clock source
// ----------------------------------------
module qcp_tick (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [3:0] src_in,
  input wire logic [1:0] sel_in,
  output logic tick_out
);
  logic sel_lvl;
  logic prev_reg;
  assign sel_lvl = src_in[sel_in];
  // Edge counts when the previous sample was low; reset clears that sample to low
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sel_lvl;
    end
  end
  assign tick_out = sel_lvl & ~prev_reg;
endmodule

// file: tb/qcp_checker_assertions.sv
module qcp_checker
  import qcp_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic pwm_pin0_out,
  input wire logic pwm_pin1_out,
  input wire logic first_irq_out,
  input wire logic fourth_irq_out
);
  // ----------------------------------------
  // Bus and output checks
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Write then read of one register, back to back
  sequence wr_rd(logic [2:0] a);
    wr_in && addr_in == a ##1 rd_in && addr_in == a;
  endsequence

  read_idle_zero_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  clk_sel_rb_a: assert property (wr_rd(ADDR_CLK_SEL) |=> rdata_out == $past(wdata_in, 2))
    else $error("clock select readback wrong");
  cfg1_rb_a: assert property (wr_rd(ADDR_CFG1) |=> rdata_out == $past(wdata_in, 2))
    else $error("config one readback wrong");
  cfg2_rb_a: assert property (wr_rd(ADDR_CFG2) |=> rdata_out == $past(wdata_in, 2))
    else $error("config two readback wrong");
  run_rb_a: assert property (wr_rd(ADDR_RUN) |=> rdata_out == ($past(wdata_in, 2) & 8'h0F))
    else $error("run register readback wrong");
  run_reserved_a: assert property (rd_in && addr_in == ADDR_RUN |=> rdata_out[7:4] == 4'h0)
    else $error("run register upper bits not zero");
  irq_a_pulse_a: assert property ($rose(first_irq_out) |=> !first_irq_out)
    else $error("first interrupt longer than one cycle");
  irq_d_pulse_a: assert property (fourth_irq_out |=> !fourth_irq_out)
    else $error("fourth interrupt longer than one cycle");
  // Registered pin lags the enable by one cycle, so look two edges on
  pwm0_off_a: assert property (wr_in && addr_in == ADDR_CFG1 && !wdata_in[CFG1_PWM0]
    |-> ##2 !pwm_pin0_out)
    else $error("first pwm pin active while disabled");
  pwm1_off_a: assert property (wr_in && addr_in == ADDR_CFG1 && !wdata_in[CFG1_PWM1]
    |-> ##2 !pwm_pin1_out)
    else $error("second pwm pin active while disabled");
endmodule

bind quad_counter_pwm_capture qcp_checker u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .pwm_pin0_out(pwm_pin0_out), .pwm_pin1_out(pwm_pin1_out),
  .first_irq_out(first_irq_out), .fourth_irq_out(fourth_irq_out));

// file: tb/quad_counter_pwm_capture_tb.sv
`define CHECK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module quad_counter_pwm_capture_tb
  import qcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in, rst_n_in, wr_in, rd_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, v;
  logic [6:0] src;
  logic [3:0] cap;
  logic pwm_pin0_out, pwm_pin1_out, first_irq_out, second_irq_out;
  logic third_irq_out, fourth_irq_out;
  int n_fail = 0;
  int num_checks = 0;
  int irq_a = 0;
  int irq_b = 0;
  int irq_c = 0;
  int irq_d = 0;
  int n, highs;

  // Sources: bits 3..0 are the port pins, 6..4 the shared internal clocks
  quad_counter_pwm_capture dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ext_clock_pins_in(src[3:0]),
    .int_clocks_in(src[6:4]), .capture_sources_in(cap), .rdata_out(rdata_out),
    .pwm_pin0_out(pwm_pin0_out), .pwm_pin1_out(pwm_pin1_out),
    .first_irq_out(first_irq_out), .second_irq_out(second_irq_out),
    .third_irq_out(third_irq_out), .fourth_irq_out(fourth_irq_out));

  // ----------------------------------------
  // Clock, interrupt tally, watchdog
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (first_irq_out === 1'b1) irq_a++;
    if (second_irq_out === 1'b1) irq_b++;
    if (third_irq_out === 1'b1) irq_c++;
    if (fourth_irq_out === 1'b1) irq_d++;
  end
  // Whole run is about 40 us, so this only trips on a hang
  initial begin
    #200_000;
    n_fail++;
    end_of_test();
  end

  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Bus tasks, entered just after a rising edge
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    v = rdata_out;
    `CHECK(v, e)
    @(posedge clock_in);
  endtask
  // Write then read with no gap, as the bus allows
  task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    `CHECK(rdata_out, e)
    @(posedge clock_in);
  endtask
  // Source pulses three cycles high and low, well above the sampling limit
  task automatic step(input int b, input int cnt);
    repeat (cnt) begin
      src[b] <= 1'b1;
      repeat (3) @(posedge clock_in);
      src[b] <= 1'b0;
      repeat (3) @(posedge clock_in);
    end
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    src = 7'h00;
    cap = 4'h0;
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    rd_chk(ADDR_CFG1, CFG_RESET);
    rd_chk(ADDR_CFG2, CFG_RESET);
    rd_chk(ADDR_RUN, 8'h00);
    wr_rd(ADDR_CLK_SEL, 8'hE4, 8'hE4);
    wr_rd(ADDR_CFG1, 8'hA5, 8'hA5);
    wr_rd(ADDR_CFG2, 8'h9C, 8'h9C);
    wr_rd(ADDR_RUN, 8'hFF, 8'h0F);
    wr(ADDR_RUN, 8'h00);
    // A, B, C on their pins, D on the third internal clock; A, D up, C down
    // Clock select only rewritten while every counter is stopped
    wr(ADDR_CLK_SEL, 8'hC0);
    wr(ADDR_CFG2, 8'h00);
    wr(ADDR_CFG1, 8'h90);
    wr(ADDR_CNT_A, 8'h03);
    wr(ADDR_CNT_D, 8'h02);
    wr(ADDR_CNT_C, 8'h05);
    wr(ADDR_RUN, 8'h0D);
    step(0, 4);
    step(6, 3);
    step(2, 2);
    rd_chk(ADDR_CNT_A, 8'h03);
    `CHECK(irq_a, 1)
    rd_chk(ADDR_CNT_D, 8'h02);
    `CHECK(irq_d, 1)
    rd_chk(ADDR_CNT_C, 8'h04);
    // Down reload lands on the compare value itself, so one pulse
    `CHECK(irq_c, 1)
    wr(ADDR_RUN, 8'h00);
    step(0, 2);
    rd_chk(ADDR_CNT_A, 8'h03);
    // Chained low pair, only the low enable set, carry into the high byte
    wr(ADDR_CFG1, 8'h94);
    wr(ADDR_CNT_A, 8'hFF);
    wr(ADDR_RUN, 8'h01);
    step(0, 257);
    rd_chk(ADDR_CNT_A, 8'h00);
    rd_chk(ADDR_CNT_B, 8'h01);
    wr(ADDR_RUN, 8'h00);
    // Capture on each edge mode, count frozen at 2 meanwhile
    wr(ADDR_CFG1, 8'h90);
    wr(ADDR_CNT_A, 8'h00);
    wr(ADDR_RUN, 8'h01);
    step(0, 3);
    for (int f = 1; f < 4; f++) begin
      wr(ADDR_CFG2, 8'(f << CFG2_CAPF));
      repeat (4) @(posedge clock_in);
      n = irq_a;
      cap[0] <= 1'b1;
      repeat (6) @(posedge clock_in);
      `CHECK(irq_a - n, (f != 2) ? 1 : 0)
      cap[0] <= 1'b0;
      repeat (6) @(posedge clock_in);
      `CHECK(irq_a - n, (f == 3) ? 2 : 1)
    end
    // Second line follows the same capture events: 1 + 1 + 2
    `CHECK(irq_b, 4)
    step(0, 2);
    rd_chk(ADDR_CNT_A, 8'h02);
    rd_chk(ADDR_CNT_B, 8'h01);
    wr(ADDR_CFG2, 8'h00);
    rd_chk(ADDR_CNT_A, 8'h04);
    // Unchained PWM on the first pin: 64 of 256 steps below compare
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_CFG1, 8'h01);
    wr(ADDR_CNT_A, 8'h40);
    wr(ADDR_RUN, 8'h01);
    rd_chk(ADDR_CNT_A, 8'h04);
    highs = 0;
    n = irq_a;
    for (int i = 0; i < 256; i++) begin
      step(0, 1);
      @(negedge clock_in);
      if (pwm_pin0_out === 1'b1) highs++;
      `CHECK(pwm_pin1_out, 1'b0)
      @(posedge clock_in);
    end
    `CHECK(highs, 64)
    // A PWM counter raises no compare interrupt
    `CHECK(irq_a - n, 0)
    // PWM on A with capture on B: only the second line pulses
    wr(ADDR_CFG2, 8'h10);
    n = irq_b;
    cap[0] <= 1'b1;
    repeat (6) @(posedge clock_in);
    cap[0] <= 1'b0;
    `CHECK(irq_b - n, 1)
    wr(ADDR_CFG2, 8'h00);
    wr(ADDR_CFG1, 8'h00);
    wr(ADDR_RUN, 8'h00);
    end_of_test();
  end
endmodule
